// file: logic/periph_id_pin_mux.sv
// Peripheral identifier glue and port A pin multiplexing.
// Assumes peripherals, clock gates and the control logic share CORE_CLK;
// pad inputs and external interrupt pins are asynchronous.
// Gate and interrupt vectors are 32 identifiers wide; port A has LINES lines.
`timescale 1ns/100ps

module periph_id_pin_mux
  import periph_mux_pkg::*;
#(
  parameter int LINES = 32
)
(
  input  wire logic             CORE_CLK,
  input  wire logic             ARST_N,
  input  wire logic             CLK_EN,
  input  wire logic [31:0]      PERIPH_IRQ,
  input  wire logic [6:0]       SYS_IRQ,
  input  wire logic             FAST_INT_PIN,
  input  wire logic [2:0]       EXT_INT_PIN,
  input  clk_cmd_type           CLK_CMD,
  input  conv_ctrl_type         CONV_CTRL,
  input  pio_ctrl_type          PIO_CTRL,
  input  periph_drive_type      FUNC_A,
  input  periph_drive_type      FUNC_B,
  input  wire logic [LINES-1:0] PAD_IN,
  output logic [31:0]           IRQ_SOURCE,
  output logic [31:0]           PERIPH_CLK_EN,
  output logic                  SYS_CLK_EN,
  output logic [LINES-1:0]      PAD_OUT,
  output logic [LINES-1:0]      PAD_OE,
  output logic [LINES-1:0]      PAD_PULLUP,
  output logic [LINES-1:0]      PERIPH_SELECT_STATUS,
  output logic [LINES-1:0]      FUNC_A_IN,
  output logic [LINES-1:0]      FUNC_B_IN
);

  // Line whose function B output feeds a given line.
  // Two output-only signals appear on two lines each, so those lines read
  // the drive of their twin rather than a bit of their own.
  function automatic int b_source(input int line);
    if (line == int'(`PA_B_DUP_0))
    begin
      return int'(`PA_B_DUP_0_SRC);
    end
    if (line == int'(`PA_B_DUP_1))
    begin
      return int'(`PA_B_DUP_1_SRC);
    end
    return line;
  endfunction

  // Synchroniser stages for interrupt pins and pads.
  logic [3:0]       ext_meta;
  logic [3:0]       ext_sync;
  logic [LINES-1:0] pad_meta;
  logic [LINES-1:0] pad_sync;

  // Next values of the interrupt and clock gate vectors.
  logic [31:0]      next_irq;
  logic [31:0]      next_gate;
  logic [31:0]      cmd_set;
  logic [31:0]      cmd_clr;

  // Converter clock state machine.
  conv_state_type   conv_state;
  conv_state_type   next_conv_state;

  // Line selection and multiplexer results.
  logic [LINES-1:0] ab_select;
  logic [LINES-1:0] sel_a;
  logic [LINES-1:0] sel_b;
  logic [LINES-1:0] next_out;
  logic [LINES-1:0] next_oe;
  logic [LINES-1:0] has_b;

  // Lines that carry a function B signal; the others never drive under B.
  assign has_b = LINES'(`PORT_A_HAS_B);

  // Two-stage synchronisers for external interrupt pins and pads.
  // A pin change therefore reaches IRQ_SOURCE on the third enabled edge.
  always_ff @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      ext_meta <= 4'h0;
      ext_sync <= 4'h0;
      pad_meta <= '0;
      pad_sync <= '0;
    end
    else if (CLK_EN)
    begin
      ext_meta <= {EXT_INT_PIN, FAST_INT_PIN};
      ext_sync <= ext_meta;
      pad_meta <= PAD_IN;
      pad_sync <= pad_meta;
    end
  end

  // Source lines by identifier; system sources merge onto one line.
  // Reserved sources are forced low so that a stray input cannot raise them.
  always_comb
  begin
    next_irq = PERIPH_IRQ & ~`RESERVED_MASK;
    next_irq[`ID_FAST_INT] = ext_sync[0];
    next_irq[`ID_SYSTEM] = |SYS_IRQ;
    next_irq[`ID_EXT_INT_0] = ext_sync[1];
    next_irq[`ID_EXT_INT_1] = ext_sync[2];
    next_irq[`ID_EXT_INT_2] = ext_sync[3];
  end

  // Registered interrupt source vector.
  always_ff @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      IRQ_SOURCE <= 32'h0000_0000;
    end
    else if (CLK_EN)
    begin
      IRQ_SOURCE <= next_irq;
    end
  end

  // Commands on ungated identifiers are masked off; set wins over clear.
  // The converter bit follows its own state machine, never a command.
  always_comb
  begin
    cmd_set = CLK_CMD.set & ~`NO_CLOCK_MASK;
    cmd_clr = CLK_CMD.clr & ~`NO_CLOCK_MASK;
    next_gate = (PERIPH_CLK_EN & ~cmd_clr) | cmd_set;
    next_gate[`ID_CONVERTER] = (next_conv_state == CONV_CLK_ON);
  end

  // Converter clock starts on a request and, in sleep, ends per conversion.
  // A request in the same cycle as a completion keeps the clock running.
  always_comb
  begin
    next_conv_state = conv_state;
    unique case (conv_state)
      CONV_CLK_OFF:
      begin
        if (CONV_CTRL.req)
        begin
          next_conv_state = CONV_CLK_ON;
        end
      end
      CONV_CLK_ON:
      begin
        if (CONV_CTRL.done && CONV_CTRL.sleep && !CONV_CTRL.req)
        begin
          next_conv_state = CONV_CLK_OFF;
        end
      end
    endcase
  end

  // Converter clock state.
  always_ff @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      conv_state <= CONV_CLK_OFF;
    end
    else if (CLK_EN)
    begin
      conv_state <= next_conv_state;
    end
  end

  // Peripheral clock gates; system peripherals keep a running clock.
  // SYS_CLK_EN stays a flip-flop so that every output leaves a register.
  always_ff @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      PERIPH_CLK_EN <= `CLK_GATE_RESET;
      SYS_CLK_EN    <= 1'b1;
    end
    else if (CLK_EN)
    begin
      PERIPH_CLK_EN <= next_gate;
      SYS_CLK_EN    <= 1'b1;
    end
  end

  // Peripheral select status; every line resets to general I/O.
  // A set and a clear of one line in the same cycle leave it set.
  always_ff @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      PERIPH_SELECT_STATUS <= `PORT_A_PSR_RESET;
    end
    else if (CLK_EN)
    begin
      PERIPH_SELECT_STATUS <= (PERIPH_SELECT_STATUS & ~PIO_CTRL.psr_clr)
                              | PIO_CTRL.psr_set;
    end
  end

  // Function A or B choice; a B request wins over an A request.
  // The choice only matters while the status bit of the line is high.
  always_ff @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      ab_select <= `PORT_A_AB_RESET;
    end
    else if (CLK_EN)
    begin
      ab_select <= (ab_select & ~PIO_CTRL.sel_a) | PIO_CTRL.sel_b;
    end
  end

  // Pull-ups come out of reset enabled on every line.
  // This keeps undriven pads at a static level as soon as reset ends.
  always_ff @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      PAD_PULLUP <= `PORT_A_PU_RESET;
    end
    else if (CLK_EN)
    begin
      PAD_PULLUP <= (PAD_PULLUP & ~PIO_CTRL.pull_clr) | PIO_CTRL.pull_set;
    end
  end

  // Per-line multiplexer of general I/O, function A and function B.
  // General I/O takes the line whenever its status bit is low.
  genvar g;
  generate
    for (g = 0; g < LINES; g++)
    begin : line_mux
      // Bit of the function B drive that this line shows.
      localparam int SRC = b_source(g);
      // Status low means general I/O; the A/B bit picks the function.
      assign sel_a[g] = PERIPH_SELECT_STATUS[g] & ~ab_select[g];
      assign sel_b[g] = PERIPH_SELECT_STATUS[g] & ab_select[g];
      // Function B output may be a copy of another line's.
      always_comb
      begin
        if (sel_a[g])
        begin
          next_out[g] = FUNC_A.out[g];
          next_oe[g]  = FUNC_A.oe[g];
        end
        else if (sel_b[g])
        begin
          next_out[g] = has_b[g] & FUNC_B.out[SRC];
          next_oe[g]  = has_b[g] & FUNC_B.oe[SRC];
        end
        else
        begin
          next_out[g] = PIO_CTRL.gpio_out[g];
          next_oe[g]  = PIO_CTRL.gpio_oe[g];
        end
      end
    end
  endgenerate

  // Pad drive; outputs stay off until a function or general output drives.
  // Level and enable change on the same edge so the pad sees no mixed state.
  always_ff @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      PAD_OUT <= '0;
      PAD_OE  <= '0;
    end
    else if (CLK_EN)
    begin
      PAD_OUT <= next_out;
      PAD_OE  <= next_oe;
    end
  end

  // Pad levels return only to the function that the line selects.
  // A line in general I/O mode returns zero to both functions.
  always_ff @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      FUNC_A_IN <= '0;
      FUNC_B_IN <= '0;
    end
    else if (CLK_EN)
    begin
      FUNC_A_IN <= pad_sync & sel_a;
      FUNC_B_IN <= pad_sync & sel_b & has_b;
    end
  end

endmodule

// file: logic/periph_mux_params.svh
// Fixed numbers of the peripheral identifier and port A multiplexing glue.
// Included by the package alone; holds definitions only.
`ifndef PERIPH_MUX_PARAMS_SVH
`define PERIPH_MUX_PARAMS_SVH

// Identifier of each interrupt source and clock gate.
`define ID_FAST_INT      5'd0
`define ID_SYSTEM        5'd1
`define ID_IO_PORT_A     5'd2
`define ID_IO_PORT_B     5'd3
`define ID_IO_PORT_C     5'd4
`define ID_CONVERTER     5'd5
`define ID_RESERVED_0    5'd15
`define ID_RESERVED_1    5'd16
`define ID_USB_HOST      5'd20
`define ID_EXT_INT_0     5'd29
`define ID_EXT_INT_1     5'd30
`define ID_EXT_INT_2     5'd31

// Gates that set and clear commands never touch.
`define NO_CLOCK_MASK    32'he010_0023
// Interrupt sources that carry no peripheral line.
`define RESERVED_MASK    32'h0001_8000
`define CLK_GATE_RESET   32'h0000_0000

// Port A lines that carry a function B signal.
`define PORT_A_HAS_B     32'hffc0_0c3b
// Port A lines whose function B output is a copy of another line's.
`define PA_B_DUP_0       5'd23
`define PA_B_DUP_0_SRC   5'd10
`define PA_B_DUP_1       5'd24
`define PA_B_DUP_1_SRC   5'd11
`define PORT_A_PSR_RESET 32'h0000_0000
`define PORT_A_AB_RESET  32'h0000_0000
`define PORT_A_PU_RESET  32'hffff_ffff

`endif

// file: logic/periph_mux_pkg.sv
// Types shared by the identifier and pin multiplexing glue and its bench.
// Assumes the constants header sits beside it.
package periph_mux_pkg;
  `include "periph_mux_params.svh"

  // Clock gate commands, one bit per identifier, one-cycle masks.
  typedef struct packed {
    logic [31:0] set;
    logic [31:0] clr;
  } clk_cmd_type;

  // Converter handshake that steers its automatic clock.
  typedef struct packed {
    logic req;
    logic done;
    logic sleep;
  } conv_ctrl_type;

  // Port A line control; the masks are one-cycle pulses, the last two levels.
  typedef struct packed {
    logic [31:0] psr_set;
    logic [31:0] psr_clr;
    logic [31:0] sel_b;
    logic [31:0] sel_a;
    logic [31:0] pull_set;
    logic [31:0] pull_clr;
    logic [31:0] gpio_out;
    logic [31:0] gpio_oe;
  } pio_ctrl_type;

  // One peripheral function's drive toward the lines, indexed by line.
  typedef struct packed {
    logic [31:0] out;
    logic [31:0] oe;
  } periph_drive_type;

  typedef enum logic {CONV_CLK_OFF, CONV_CLK_ON} conv_state_type;
endpackage

// file: dv/periph_id_pin_mux_assertions.sv
// Checker for gate commands, interrupt routing and port A selection timing.
// Sees only the top module ports; bound to every instance below.
`timescale 1ns/100ps
module periph_id_pin_mux_assertions
  import periph_mux_pkg::*;
(
  input wire logic   CORE_CLK,
  input wire logic   ARST_N,
  input wire logic   CLK_EN,
  input wire logic [31:0] PERIPH_IRQ,
  input wire logic [6:0]  SYS_IRQ,
  input wire logic   FAST_INT_PIN,
  input wire logic [2:0]  EXT_INT_PIN,
  input clk_cmd_type CLK_CMD,
  input conv_ctrl_type CONV_CTRL,
  input pio_ctrl_type PIO_CTRL,
  input periph_drive_type FUNC_B,
  input wire logic [31:0] IRQ_SOURCE,
  input wire logic [31:0] PERIPH_CLK_EN,
  input wire logic   SYS_CLK_EN,
  input wire logic [31:0] PAD_OE,
  input wire logic [31:0] PERIPH_SELECT_STATUS
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!ARST_N);
  // Line 0 handed to function B, then left alone for a cycle.
  sequence s_take_b0;
    CLK_EN && PIO_CTRL.psr_set[0] && PIO_CTRL.sel_b[0];
  endsequence
  sequence s_quiet0;
    CLK_EN && !PIO_CTRL.psr_clr[0] && !PIO_CTRL.sel_a[0];
  endsequence
  property p_sel_b0;
    s_take_b0 ##1 s_quiet0 |-> PERIPH_SELECT_STATUS[0] ##1 PAD_OE[0] == $past(FUNC_B.oe[0]);
  endproperty
  property p_sys_clk; SYS_CLK_EN; endproperty
  property p_reserved; IRQ_SOURCE[16:15] == 2'h0; endproperty
  property p_nogate; (PERIPH_CLK_EN & 32'he010_0003) == 32'h0; endproperty
  property p_gate_cmd;
    CLK_EN |=> (~PERIPH_CLK_EN & $past(CLK_CMD.set) & 32'h1fef_ffdc) == 32'h0
      && (PERIPH_CLK_EN & $past(CLK_CMD.clr) & ~$past(CLK_CMD.set) & 32'h1fef_ffdc) == 32'h0;
  endproperty
  property p_irq_map;
    CLK_EN |=> (IRQ_SOURCE & 32'h1ffe_7ffc) == ($past(PERIPH_IRQ) & 32'h1ffe_7ffc);
  endproperty
  property p_sys_or; CLK_EN |=> IRQ_SOURCE[1] == |$past(SYS_IRQ); endproperty
  property p_pins;
    CLK_EN [*4] |-> {IRQ_SOURCE[31:29], IRQ_SOURCE[0]} ==
      {$past(EXT_INT_PIN, 3), $past(FAST_INT_PIN, 3)};
  endproperty
  property p_conv_on; CLK_EN && CONV_CTRL.req |=> PERIPH_CLK_EN[5]; endproperty
  property p_conv_off;
    CLK_EN && CONV_CTRL.done && CONV_CTRL.sleep && !CONV_CTRL.req |=> !PERIPH_CLK_EN[5];
  endproperty
  a_sel_b0: assert property (p_sel_b0)
    else $error("line 0 function B selection late or wrong");
  a_sys_clk: assert property (p_sys_clk)
    else $error("system clock gate low");
  a_reserved: assert property (p_reserved)
    else $error("reserved source raised");
  a_nogate: assert property (p_nogate)
    else $error("ungated identifier has clock enabled");
  a_gate_cmd: assert property (p_gate_cmd)
    else $error("clock gate command not applied");
  a_irq_map: assert property (p_irq_map)
    else $error("peripheral interrupt misrouted");
  a_sys_or: assert property (p_sys_or)
    else $error("source 1 not the OR of system interrupts");
  a_pins: assert property (p_pins)
    else $error("pin interrupt misrouted");
  a_conv_on: assert property (p_conv_on)
    else $error("converter clock did not start");
  a_conv_off: assert property (p_conv_off)
    else $error("converter clock did not stop");
endmodule
bind periph_id_pin_mux periph_id_pin_mux_assertions i_chk (.CORE_CLK, .ARST_N, .CLK_EN,
  .PERIPH_IRQ, .SYS_IRQ, .FAST_INT_PIN, .EXT_INT_PIN, .CLK_CMD, .CONV_CTRL, .PIO_CTRL,
  .FUNC_B, .IRQ_SOURCE, .PERIPH_CLK_EN, .SYS_CLK_EN, .PAD_OE, .PERIPH_SELECT_STATUS);

// file: dv/periph_pads.sv
// Peripheral functions and pads at the far side of the port A lines.
// Function enables come from the bench; outputs carry fixed patterns.
`timescale 1ns/100ps
module periph_pads
  import periph_mux_pkg::*;
(
  input  wire logic [31:0] a_oe,
  input  wire logic [31:0] b_oe,
  input  wire logic [31:0] pad_out,
  input  wire logic [31:0] pad_oe,
  input  wire logic [31:0] pad_pullup,
  output periph_drive_type func_a,
  output periph_drive_type func_b,
  output logic [31:0]      pad_in
);
  // Each function drives its own pattern under the enables.
  assign func_a = '{out: 32'h0f0f_0f0f, oe: a_oe};
  assign func_b = '{out: 32'h3c3c_3c3c, oe: b_oe};
  // A released pad rests at its pull-up; without one it shows the opposite
  // of its last drive, so a late sample cannot pass by luck.
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & (pad_pullup | ~pad_out));
endmodule

// file: dv/testbench.sv
// Self-checking bench for the identifier and port A multiplexing glue.
// Drives inputs 1 ns after each rising edge; the pads model sits opposite.
`timescale 1ns/100ps
module testbench
  import periph_mux_pkg::*;
;
  logic CORE_CLK = 1'h0, ARST_N = 1'h0, CLK_EN = 1'h1, FAST_INT_PIN = 1'h0, SYS_CLK_EN;
  logic [31:0] PERIPH_IRQ = 32'h0, a_oe = 32'h0, b_oe = 32'h0, PAD_IN, PAD_OUT, PAD_OE;
  logic [31:0] IRQ_SOURCE, PERIPH_CLK_EN, PAD_PULLUP, PERIPH_SELECT_STATUS, FUNC_A_IN, FUNC_B_IN;
  logic [6:0] SYS_IRQ = 7'h0;
  logic [2:0] EXT_INT_PIN = 3'h0;
  clk_cmd_type CLK_CMD = '0;
  conv_ctrl_type CONV_CTRL = '0;
  pio_ctrl_type PIO_CTRL = '0;
  periph_drive_type FUNC_A, FUNC_B;
  int bad_count = 0, checks = 0;
  logic [3:0] conv_tab [4] = '{4'h9, 4'h5, 4'h6, 4'hf};
  periph_id_pin_mux i_periph_id_pin_mux (.CORE_CLK, .ARST_N, .CLK_EN, .PERIPH_IRQ, .SYS_IRQ,
    .FAST_INT_PIN, .EXT_INT_PIN, .CLK_CMD, .CONV_CTRL, .PIO_CTRL, .FUNC_A, .FUNC_B, .PAD_IN,
    .IRQ_SOURCE, .PERIPH_CLK_EN, .SYS_CLK_EN, .PAD_OUT, .PAD_OE, .PAD_PULLUP,
    .PERIPH_SELECT_STATUS, .FUNC_A_IN, .FUNC_B_IN);
  periph_pads i_periph_pads (.a_oe(a_oe), .b_oe(b_oe), .pad_out(PAD_OUT), .pad_oe(PAD_OE),
    .pad_pullup(PAD_PULLUP), .func_a(FUNC_A), .func_b(FUNC_B), .pad_in(PAD_IN));
  // Free-running 250 MHz clock.
  always #2 CORE_CLK = ~CORE_CLK;
  task automatic step(int n);
    repeat (n) @(posedge CORE_CLK);
    #1;
  endtask
  task automatic cmp(string name, logic [31:0] exp, logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic complete_run;
    if (bad_count == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Pulses one set of port A selection masks, then lets the pads settle.
  task automatic pio(logic [31:0] ps, logic [31:0] pc, logic [31:0] sb, logic [31:0] sa);
    PIO_CTRL.psr_set = ps;
    PIO_CTRL.psr_clr = pc;
    PIO_CTRL.sel_b = sb;
    PIO_CTRL.sel_a = sa;
    step(1);
    PIO_CTRL = '0;
    step(3);
  endtask
  task automatic t_gates;
    CLK_CMD.set = 32'hffff_ffff;
    step(1);
    cmp("clk_after_set", 32'h1fef_ffdc, PERIPH_CLK_EN);
    CLK_CMD = '{set: 32'h0000_1000, clr: 32'hffff_ffff};
    step(1);
    CLK_CMD = '0;
    cmp("clk_after_clr", 32'h0000_1000, PERIPH_CLK_EN);
    foreach (conv_tab[i])
    begin
      CONV_CTRL = conv_tab[i][3:1];
      step(1);
      CONV_CTRL = '0;
      step(1);
      cmp("conv_clk", {31'h0, conv_tab[i][0]}, {31'h0, PERIPH_CLK_EN[5]});
    end
  endtask
  task automatic t_irq;
    PERIPH_IRQ = 32'hffff_ffff;
    step(2);
    cmp("irq_periph", 32'h1ffe_7ffc, IRQ_SOURCE);
    PERIPH_IRQ = 32'h0;
    for (int i = 0; i < 7; i++)
    begin
      SYS_IRQ = 7'h1 << i;
      step(2);
      cmp("irq_system", 32'h0000_0002, IRQ_SOURCE);
    end
    SYS_IRQ = 7'h0;
    FAST_INT_PIN = 1'h1;
    EXT_INT_PIN = 3'h5;
    step(4);
    cmp("irq_pins", 32'ha000_0001, IRQ_SOURCE);
  endtask
  task automatic t_pins;
    b_oe = 32'h0000_0c00;
    pio(32'hffff_ffff, 32'h0, 32'hffff_ffff, 32'h0);
    cmp("status_b", 32'hffff_ffff, PERIPH_SELECT_STATUS);
    cmp("oe_dup", 32'h0180_0c00, PAD_OE);
    b_oe = 32'hffff_ffff;
    step(2);
    cmp("oe_b", 32'hffc0_0c3b, PAD_OE);
    cmp("out_b", 32'h3d80_0c38, PAD_OUT);
    step(3);
    cmp("in_b_on", 32'h3d80_0c38, FUNC_B_IN);
    pio(32'h0, 32'h0, 32'h0, 32'hffff_ffff);
    cmp("oe_a_off", 32'h0, PAD_OE);
    step(1);
    cmp("in_a", 32'hffff_ffff, FUNC_A_IN);
    cmp("in_b", 32'h0, FUNC_B_IN);
    a_oe = 32'hffff_ffff;
    step(2);
    cmp("oe_a", 32'hffff_ffff, PAD_OE);
    cmp("out_a", 32'h0f0f_0f0f, PAD_OUT);
    pio(32'h0, 32'hffff_ffff, 32'h0, 32'h0);
    cmp("status_gpio", 32'h0, PERIPH_SELECT_STATUS);
    cmp("oe_gpio", 32'h0, PAD_OE);
    PIO_CTRL = '{gpio_out: 32'h0000_ffff, gpio_oe: 32'h00ff_00ff, pull_clr: 32'hffff_0000,
      default: '0};
    step(1);
    PIO_CTRL.pull_clr = 32'h0;
    cmp("out_gpio", 32'h0000_ffff, PAD_OUT);
    cmp("oe_gpio_on", 32'h00ff_00ff, PAD_OE);
    cmp("pullup_clr", 32'h0000_ffff, PAD_PULLUP);
  endtask
  // Main sequence: reset values first, then each scenario.
  initial
  begin
    step(5);
    cmp("pullup_rst", 32'hffff_ffff, PAD_PULLUP);
    cmp("status_rst", 32'h0, PERIPH_SELECT_STATUS);
    cmp("oe_rst", 32'h0, PAD_OE);
    cmp("sys_clk_rst", 32'h1, {31'h0, SYS_CLK_EN});
    ARST_N = 1'h1;
    t_gates();
    t_irq();
    t_pins();
    complete_run();
  end
  // Watchdog well past the 56 cycles the scenarios need.
  initial
  begin
    #8000;
    bad_count++;
    complete_run();
  end
endmodule
